// file: verilog/cac_consts.svh
// Register offsets, field positions, reset values and widths of the channel adder.
// Assumes a 4-bit word-aligned register port with 32-bit data.
`ifndef CAC_CONSTS_SVH
`define CAC_CONSTS_SVH

// ==========================================
// Register port
`define CAC_ADDR_W 4
`define CAC_DATA_W 32
`define CAC_OFF_COUNT 4'h0
`define CAC_OFF_CMD_ADDR 4'h4
`define CAC_OFF_STATUS 4'h8

// ==========================================
// Field positions in the 32-bit data word
`define CAC_PAR_LSB 24
`define CAC_ST_CHECK_BIT 0
`define CAC_ST_MISMATCH_BIT 1
`define CAC_ST_OP_LSB 4

// ==========================================
// Reset values (odd parity of an all-zero byte is one)
`define CAC_COUNT_RST 17'h00000
`define CAC_CMD_ADDR_RST 21'h000000
`define CAC_PAR_RST 3'h7
`define CAC_SUM_RST 24'h000000

`endif

// file: verilog/cac_pkg.sv
// Types shared by the channel adder modules.
// Assumes the constants header is on the include path.
package cac_pkg;

	// ==========================================
	// Adder operation selected by the sequencing strobes
	typedef enum logic [1:0] {
		CAC_OP_NONE,
		CAC_OP_LOW_PLUS_COUNT,
		CAC_OP_COUNT_DEC,
		CAC_OP_CMD_INC
	} cac_op_t;

	// ==========================================
	// Whole state of the adder top
	typedef struct packed {
		logic [7:23] count;
		logic [0:2] count_par;
		logic [0:20] cmd_addr;
		logic [0:2] cmd_par;
		logic [0:23] sum_hold;
		logic [0:2] par_hold;
		logic mismatch_hold;
		logic control_check;
		cac_op_t last_op;
		logic [31:0] rd_data;
	} cac_state_t;

endpackage

// file: verilog/cac_adder_core.sv
// Combinational adder: three-bit full adder at positions 21-23, carry/borrow
// ripple at positions 0-20, parity prediction and result parity per byte.
// Assumes the caller gates at most one operation at a time.
`timescale 1ns/1ps

module cac_adder_core
	import cac_pkg::*;
(
	input wire logic i_gate_count,
	input wire logic i_gate_low_address_bits,
	input wire logic i_gate_count_minus1,
	input wire logic i_gate_cmd_addr,
	input wire logic i_gate_cmd_plus1,
	input wire logic [7:23] i_count,
	input wire logic [0:20] i_cmd_addr,
	input wire logic [21:23] i_low_address_bits,
	output logic [0:23] o_sum,
	output logic [0:2] o_pred_par,
	output logic [0:2] o_result_par
);

	logic [0:23] op_a;
	logic [0:23] op_b;
	logic [0:23] carry_in;
	logic [21:23] fa_carry;
	logic [0:20] inc;
	logic [0:20] brw;
	logic full_add_carry;

	// ==========================================
	// Operand gating and per-position logic
	genvar i;
	generate
		for (i = 0; i < 24; i = i + 1) begin : g_pos
			if (i >= 7 && i <= 20) begin : g_mid
				assign op_a[i] = (i_gate_count & i_count[i]) | (i_gate_cmd_addr & i_cmd_addr[i]);
			end else if (i < 7) begin : g_hi
				assign op_a[i] = i_gate_cmd_addr & i_cmd_addr[i];
			end else begin : g_lo
				assign op_a[i] = i_gate_count & i_count[i];
			end
			if (i >= 21) begin : g_full
				assign op_b[i] = i_gate_low_address_bits & i_low_address_bits[i];
				assign o_sum[i] = op_a[i] ^ op_b[i] ^ carry_in[i];
				assign fa_carry[i] = (op_a[i] & op_b[i]) | (carry_in[i] & (op_a[i] ^ op_b[i]));
				if (i == 23) begin : g_c23
					assign carry_in[i] = 1'b0;
				end else begin : g_cfa
					assign carry_in[i] = fa_carry[i + 1];
				end
			end else begin : g_rip
				assign op_b[i] = 1'b0;
				assign carry_in[i] = inc[i] ^ brw[i];
				assign o_sum[i] = op_a[i] ^ inc[i] ^ brw[i];
				if (i == 20) begin : g_inj
					assign inc[i] = full_add_carry | i_gate_cmd_plus1;
					assign brw[i] = i_gate_count_minus1;
				end else if (i == 6) begin : g_cut
					// Count field wraps at bit 7 so bits 0-6 never pick up its overflow
					assign inc[i] = i_gate_cmd_addr & op_a[i + 1] & inc[i + 1];
					assign brw[i] = i_gate_cmd_addr & ~op_a[i + 1] & brw[i + 1];
				end else begin : g_chain
					assign inc[i] = op_a[i + 1] & inc[i + 1];
					assign brw[i] = ~op_a[i + 1] & brw[i + 1];
				end
			end
		end
	endgenerate

	assign full_add_carry = fa_carry[21];

	// ==========================================
	// Parity: predicted from operands and carries, result from the sum (odd)
	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_par
			assign o_pred_par[k] = ~(^op_a[8 * k +: 8] ^ ^op_b[8 * k +: 8] ^ ^carry_in[8 * k +: 8]);
			assign o_result_par[k] = ~(^o_sum[8 * k +: 8]);
		end
	endgenerate

endmodule

// file: verilog/cac_adder.sv
// Channel count / command address adder with its count and command address
// registers, sum hold, parity check and control-check latch.
// Assumes the sequencing control drives one-cycle strobes on i_sys_clk and
// software uses the plain register port with read data one cycle later.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

`include "cac_consts.svh"

// Functional notes
// - Count gate places count bits 7-23 onto adder positions 7-23.
// - Low-address gate applies three low address bits to positions 21-23.
// - Position 23 sum is the XOR of its two operands.
// - Position 23 carries into 22 when both operands are one.
// - Position 22 sum is XOR of both operands and incoming carry.
// - Position 22 carries on both-ones, or incoming carry with differing operands.
// - Position 21 sums likewise and yields full-add carry on three-bit overflow.
// - Full-add carry increments position 20 and ripples through upper count bits.
// - Load-count strobe writes held sum bits 7-23 and parity into count.
// - Count decrement lowers count by one doubleword unit.
// - Count gate with minus-one strobe injects a borrow at position 20.
// - During count decrement, sum bits 21-23 equal the count bits.
// - Parity mismatch sampled at the latch strobe sets the control-check latch on load.
// - Chained command fetch increments command address by one unit.
// - Command gate routes address bits 0-20; plus-one injects at 20.
// - Command load writes held sum bits 0-20 and parity into command address.
// - Predicted parity compared to result parity per byte flags mismatch.
// - Increment at 20 ripples so bits 0-20 equal input plus one.
// - Borrow at 20 ripples so bits 7-20 equal input minus one.
module cac_adder
	import cac_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_gate_count,
	input wire logic i_gate_low_address_bits,
	input wire logic i_gate_count_minus1,
	input wire logic i_gate_cmd_addr,
	input wire logic i_gate_cmd_plus1,
	input wire logic i_latch_adder,
	input wire logic i_load_count,
	input wire logic i_load_cmd_addr,
	input wire logic [21:23] i_low_address_bits,
	input wire logic [`CAC_ADDR_W-1:0] i_addr,
	input wire logic [`CAC_DATA_W-1:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [`CAC_DATA_W-1:0] o_rd_data,
	output logic [7:23] o_count,
	output logic [0:2] o_count_par,
	output logic [0:20] o_cmd_addr,
	output logic [0:2] o_cmd_par,
	output logic [0:23] o_adder_sum,
	output logic o_parity_check,
	output logic o_control_check
);

	// ==========================================
	// Reset image of the state
	localparam cac_state_t CAC_STATE_RST = '{
		count: `CAC_COUNT_RST,
		count_par: `CAC_PAR_RST,
		cmd_addr: `CAC_CMD_ADDR_RST,
		cmd_par: `CAC_PAR_RST,
		sum_hold: `CAC_SUM_RST,
		par_hold: `CAC_PAR_RST,
		mismatch_hold: 1'b0,
		control_check: 1'b0,
		last_op: CAC_OP_NONE,
		rd_data: 32'h00000000
	};

	cac_state_t s;
	cac_state_t next_s;

	logic [0:23] core_sum;
	logic [0:2] core_pred_par;
	logic [0:2] core_result_par;
	logic core_mismatch;
	cac_op_t cur_op;

	// ==========================================
	// Operation decode, shared by the datapath bookkeeping and the checks
	function automatic cac_op_t op_decode(
		input logic gate_count,
		input logic gate_low,
		input logic minus1,
		input logic gate_cmd,
		input logic plus1
	);
		cac_op_t op;
		op = CAC_OP_NONE;
		// Only one operation is expected at a time; the command path takes priority
		if (gate_cmd && plus1) begin
			op = CAC_OP_CMD_INC;
		end else if (gate_count && gate_low) begin
			op = CAC_OP_LOW_PLUS_COUNT;
		end else if (gate_count && minus1) begin
			op = CAC_OP_COUNT_DEC;
		end
		return op;
	endfunction

	// ==========================================
	// Register read mux
	function automatic logic [31:0] read_word(
		input logic [`CAC_ADDR_W-1:0] addr,
		input cac_state_t st
	);
		logic [31:0] w;
		w = 32'h00000000;
		unique case (addr)
			`CAC_OFF_COUNT: begin
				w[16:0] = st.count;
				w[`CAC_PAR_LSB +: 3] = st.count_par;
			end
			`CAC_OFF_CMD_ADDR: begin
				w[20:0] = st.cmd_addr;
				w[`CAC_PAR_LSB +: 3] = st.cmd_par;
			end
			`CAC_OFF_STATUS: begin
				w[`CAC_ST_CHECK_BIT] = st.control_check;
				w[`CAC_ST_MISMATCH_BIT] = st.mismatch_hold;
				w[`CAC_ST_OP_LSB +: 2] = st.last_op;
			end
			default: begin
				// Unmapped offsets read as zero
				w = 32'h00000000;
			end
		endcase
		return w;
	endfunction

	// ==========================================
	// Adder datapath
	cac_adder_core u_core (
		.i_gate_count(i_gate_count),
		.i_gate_low_address_bits(i_gate_low_address_bits),
		.i_gate_count_minus1(i_gate_count_minus1),
		.i_gate_cmd_addr(i_gate_cmd_addr),
		.i_gate_cmd_plus1(i_gate_cmd_plus1),
		.i_count(s.count),
		.i_cmd_addr(s.cmd_addr),
		.i_low_address_bits(i_low_address_bits),
		.o_sum(core_sum),
		.o_pred_par(core_pred_par),
		.o_result_par(core_result_par)
	);

	assign core_mismatch = |(core_pred_par ^ core_result_par);

	always_comb begin
		cur_op = op_decode(i_gate_count, i_gate_low_address_bits, i_gate_count_minus1,
			i_gate_cmd_addr, i_gate_cmd_plus1);
	end

	// ==========================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.rd_data = 32'h00000000;

		// Hold freezes the sum so the destination load is immune to operand changes
		if (i_latch_adder) begin
			next_s.sum_hold = core_sum;
			next_s.par_hold = core_pred_par;
			next_s.mismatch_hold = core_mismatch;
			next_s.last_op = cur_op;
		end

		if (i_wr_en) begin
			unique case (i_addr)
				`CAC_OFF_COUNT: begin
					next_s.count = i_wr_data[16:0];
					next_s.count_par = i_wr_data[`CAC_PAR_LSB +: 3];
				end
				`CAC_OFF_CMD_ADDR: begin
					next_s.cmd_addr = i_wr_data[20:0];
					next_s.cmd_par = i_wr_data[`CAC_PAR_LSB +: 3];
				end
				`CAC_OFF_STATUS: begin
					if (i_wr_data[`CAC_ST_CHECK_BIT]) begin
						next_s.control_check = 1'b0;
					end
				end
				default: begin
					next_s.control_check = next_s.control_check;
				end
			endcase
		end

		// Hardware loads come after software writes so they win a same-cycle clash
		if (i_load_count) begin
			next_s.count = s.sum_hold[7:23];
			next_s.count_par = s.par_hold;
		end
		if (i_load_cmd_addr) begin
			next_s.cmd_addr = s.sum_hold[0:20];
			next_s.cmd_par = s.par_hold;
		end

		// Set beats a software clear in the same cycle
		if ((i_load_count || i_load_cmd_addr) && s.mismatch_hold) begin
			next_s.control_check = 1'b1;
		end

		if (i_rd_en) begin
			next_s.rd_data = read_word(i_addr, s);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s <= CAC_STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================
	// Outputs, all straight from the state register
	assign o_rd_data = s.rd_data;
	assign o_count = s.count;
	assign o_count_par = s.count_par;
	assign o_cmd_addr = s.cmd_addr;
	assign o_cmd_par = s.cmd_par;
	assign o_adder_sum = s.sum_hold;
	assign o_parity_check = s.mismatch_hold;
	assign o_control_check = s.control_check;

	// ==========================================
	// Checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_dec_latched;
		(cur_op == CAC_OP_COUNT_DEC) && i_latch_adder && !i_load_count && !i_wr_en;
	endsequence

	sequence s_count_loaded;
		i_load_count && !i_latch_adder;
	endsequence

	sequence s_cmd_inc_latched;
		(cur_op == CAC_OP_CMD_INC) && i_latch_adder && !i_load_cmd_addr && !i_wr_en;
	endsequence

	sequence s_cmd_loaded;
		i_load_cmd_addr && !i_latch_adder;
	endsequence

	property p_dec_to_count;
		s_dec_latched ##1 s_count_loaded |=> s.count == $past(s.count, 2) - 17'h00008;
	endproperty

	property p_inc_to_cmd;
		s_cmd_inc_latched ##1 s_cmd_loaded |=> s.cmd_addr == $past(s.cmd_addr, 2) + 21'h000001;
	endproperty

	a_dec_count_path: assert property (p_dec_to_count)
		else $error("count decrement did not reduce count by one");

	a_cmd_inc_path: assert property (p_inc_to_cmd)
		else $error("command address increment did not add one");

	a_count_load_value: assert property (i_load_count |=>
		(s.count == $past(s.sum_hold[7:23])) && (s.count_par == $past(s.par_hold)))
		else $error("count load did not take held sum and parity");

	a_cmd_load_value: assert property (i_load_cmd_addr |=>
		(s.cmd_addr == $past(s.sum_hold[0:20])) && (s.cmd_par == $past(s.par_hold)))
		else $error("command address load did not take held sum and parity");

	a_check_on_mismatch: assert property (i_latch_adder && core_mismatch
		##1 (i_load_count || i_load_cmd_addr) |=> s.control_check)
		else $error("parity mismatch at load did not set control check");

	a_hold_frozen: assert property (!i_latch_adder |=>
		$stable(s.sum_hold) && $stable(s.par_hold))
		else $error("held sum changed without latch strobe");

	a_dec_low_unchanged: assert property (cur_op == CAC_OP_COUNT_DEC |->
		core_sum[21:23] == s.count[21:23])
		else $error("decrement altered sum bits 21 to 23");

	a_dec_value: assert property (cur_op == CAC_OP_COUNT_DEC |->
		core_sum[7:23] == s.count - 17'h00008)
		else $error("decrement sum is not count minus one doubleword");

	a_cmd_inc_value: assert property (cur_op == CAC_OP_CMD_INC |->
		core_sum[0:20] == s.cmd_addr + 21'h000001)
		else $error("increment sum is not command address plus one");

	a_low_plus_count: assert property (cur_op == CAC_OP_LOW_PLUS_COUNT |->
		core_sum[7:23] == s.count + {14'h0000, i_low_address_bits})
		else $error("setup sum is not count plus low address bits");

	a_pos23_sum: assert property (cur_op == CAC_OP_LOW_PLUS_COUNT |->
		core_sum[23] == (s.count[23] ^ i_low_address_bits[23]))
		else $error("position 23 sum is not the operand exclusive or");

	a_pos22_carry: assert property (cur_op == CAC_OP_LOW_PLUS_COUNT |->
		core_sum[22] == (s.count[22] ^ i_low_address_bits[22]
		^ (s.count[23] & i_low_address_bits[23])))
		else $error("position 22 sum ignores carry from position 23");

	a_parity_clean: assert property (i_latch_adder |=>
		s.mismatch_hold == $past(core_mismatch))
		else $error("held mismatch differs from parity compare");

	a_check_sticky: assert property (s.control_check && !(i_wr_en
		&& i_addr == `CAC_OFF_STATUS && i_wr_data[`CAC_ST_CHECK_BIT]) |=> s.control_check)
		else $error("control check cleared without software clear");

endmodule

// file: tb/cac_seq_model.sv
// Sequencing control model: drives the adder gate, latch and load strobes.
// Assumes one request at a time on i_start while o_busy is low.
`timescale 1ns/1ps

module cac_seq_model
	import cac_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire cac_op_t i_op,
	input wire logic [1:0] i_hold,
	output logic o_gate_count,
	output logic o_gate_low_address_bits,
	output logic o_gate_count_minus1,
	output logic o_gate_cmd_addr,
	output logic o_gate_cmd_plus1,
	output logic o_latch_adder,
	output logic o_load_count,
	output logic o_load_cmd_addr,
	output logic o_busy
);
	logic [1:0] wait_c;
	cac_op_t op_r;

	// ==========================================
	// Gates and latch for one cycle, load after a chosen pause
	always_ff @(posedge i_sys_clk) begin
		o_gate_count <= 1'b0;
		o_gate_low_address_bits <= 1'b0;
		o_gate_count_minus1 <= 1'b0;
		o_gate_cmd_addr <= 1'b0;
		o_gate_cmd_plus1 <= 1'b0;
		o_latch_adder <= 1'b0;
		o_load_count <= 1'b0;
		o_load_cmd_addr <= 1'b0;
		if (!i_rst_n) begin
			o_busy <= 1'b0;
			wait_c <= 2'h0;
			op_r <= CAC_OP_NONE;
		end else if (i_start && !o_busy) begin
			o_gate_count <= (i_op != CAC_OP_CMD_INC);
			o_gate_low_address_bits <= (i_op == CAC_OP_LOW_PLUS_COUNT);
			o_gate_count_minus1 <= (i_op == CAC_OP_COUNT_DEC);
			o_gate_cmd_addr <= (i_op == CAC_OP_CMD_INC);
			o_gate_cmd_plus1 <= (i_op == CAC_OP_CMD_INC);
			o_latch_adder <= 1'b1;
			wait_c <= i_hold;
			op_r <= i_op;
			o_busy <= 1'b1;
		end else if (o_busy) begin
			// Load only after the latch, so the held sum is the one written
			if (wait_c == 2'h0) begin
				o_load_count <= (op_r != CAC_OP_CMD_INC);
				o_load_cmd_addr <= (op_r == CAC_OP_CMD_INC);
				o_busy <= 1'b0;
			end else begin
				wait_c <= wait_c - 2'h1;
			end
		end
	end
endmodule

// file: tb/channel_address_count_adder_bench.sv
// Self-checking bench for the channel adder: register port tasks, a model
// of the sequencing control, and a queue of expected reads with a monitor.
// Assumes the design files and cac_consts.svh are compiled alongside.
`timescale 1ns/1ps
`include "cac_consts.svh"
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t %s", $time, m); end end

module channel_address_count_adder_bench
	import cac_pkg::*;
;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [21:23] low = 3'h0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic start = 1'b0;
	cac_op_t op = CAC_OP_NONE;
	logic [1:0] hold = 2'h0;
	logic g_cnt, g_low, g_m1, g_cmd, g_p1, latch, ld_cnt, ld_cmd, busy;
	logic [31:0] rdata;
	logic [0:23] sum;
	logic pchk, cchk;
	logic [7:23] cnt;
	logic [0:2] cpar;
	logic [0:20] cmd;
	logic [0:2] apar;
	int failures = 0;
	int comparisons = 0;
	logic [31:0] exp_q[$];
	logic rd_seen = 1'b0;

	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	cac_seq_model seq (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_start(start), .i_op(op),
		.i_hold(hold), .o_gate_count(g_cnt), .o_gate_low_address_bits(g_low),
		.o_gate_count_minus1(g_m1), .o_gate_cmd_addr(g_cmd), .o_gate_cmd_plus1(g_p1),
		.o_latch_adder(latch), .o_load_count(ld_cnt), .o_load_cmd_addr(ld_cmd), .o_busy(busy));

	cac_adder dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_gate_count(g_cnt),
		.i_gate_low_address_bits(g_low), .i_gate_count_minus1(g_m1), .i_gate_cmd_addr(g_cmd),
		.i_gate_cmd_plus1(g_p1), .i_latch_adder(latch), .i_load_count(ld_cnt),
		.i_load_cmd_addr(ld_cmd), .i_low_address_bits(low), .i_addr(addr), .i_wr_data(wdata),
		.i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata), .o_count(cnt), .o_count_par(cpar),
		.o_cmd_addr(cmd), .o_cmd_par(apar), .o_adder_sum(sum), .o_parity_check(pchk),
		.o_control_check(cchk));

	// ==========================================
	// Odd parity per byte, byte 0 being positions 0-7
	function automatic logic [2:0] podd(input logic [23:0] s);
		return {~^s[23:16], ~^s[15:8], ~^s[7:0]};
	endfunction

	function automatic logic [31:0] cword(input logic [16:0] c);
		return {5'h0, podd({7'h0, c}), 7'h0, c};
	endfunction

	function automatic logic [31:0] aword(input logic [20:0] a);
		return {5'h0, podd({a, 3'h0}), 3'h0, a};
	endfunction

	// ==========================================
	// Register port and operation tasks
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_sys_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
		@(posedge i_sys_clk);
		rd <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge i_sys_clk);
		rd <= 1'b0;
	endtask

	task automatic final_report();
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic run_op(input cac_op_t o, input logic [1:0] h);
		@(posedge i_sys_clk);
		start <= 1'b1;
		op <= o;
		hold <= h;
		@(posedge i_sys_clk);
		start <= 1'b0;
		for (int n = 0; n < 20; n++) begin
			@(posedge i_sys_clk);
			low <= 3'($urandom());
			if (busy === 1'b0) begin
				return;
			end
		end
		failures++;
		final_report();
	endtask

	task automatic chk_op(input logic [23:0] s, input logic [23:0] m, input logic [3:0] a,
		input logic [31:0] w, input logic [31:0] st);
		#1;
		`CHK(sum & m, s, "held sum")
		`CHK(pchk, 1'b0, "parity flag")
		`CHK(cchk, 1'b0, "control check")
		if (a == `CAC_OFF_COUNT) begin
			`CHK({5'h0, cpar, 7'h0, cnt}, w, "count outputs")
		end else begin
			`CHK({5'h0, apar, 3'h0, cmd}, w, "command outputs")
		end
		rd_reg(a, w);
		rd_reg(`CAC_OFF_STATUS, st);
	endtask

	// ==========================================
	// Read monitor: the oldest note meets the data one cycle after the strobe
	always @(posedge i_sys_clk) begin
		if (rd_seen) begin
			`CHK(rdata, exp_q.pop_front(), "read data")
		end
		rd_seen <= rd;
	end

	initial begin
		logic [16:0] c;
		logic [20:0] a;
		void'($urandom(32'hB27DCCA8));
		repeat (16) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		rd_reg(`CAC_OFF_COUNT, cword(17'h0));
		rd_reg(`CAC_OFF_CMD_ADDR, aword(21'h0));
		rd_reg(`CAC_OFF_STATUS, 32'h0);
		wr_reg(4'hC, 32'hFFFFFFFF);
		rd_reg(4'hC, 32'h0);
		// Every low-address value, odd counts force carries into position 20
		for (int i = 0; i < 8; i++) begin
			c = 17'($urandom());
			if (i[0]) begin
				c[2:0] = 3'h7;
			end
			if (i == 7) begin
				c = 17'h1FFFF;
			end
			wr_reg(`CAC_OFF_COUNT, cword(c));
			low <= i[2:0];
			run_op(CAC_OP_LOW_PLUS_COUNT, i[1:0]);
			c = c + 17'(i);
			chk_op({7'h0, c}, 24'hFFFFFF, `CAC_OFF_COUNT, cword(c), 32'h10);
		end
		// Decrement, including a borrow through bits 7-20 and a random low field
		for (int i = 0; i < 6; i++) begin
			c = (i == 0) ? 17'h0 : (i == 1) ? 17'h8 : 17'($urandom());
			wr_reg(`CAC_OFF_COUNT, cword(c));
			run_op(CAC_OP_COUNT_DEC, 2'($urandom()));
			c = c - 17'h8;
			chk_op({7'h0, c}, 24'hFFFFFF, `CAC_OFF_COUNT, cword(c), 32'h20);
		end
		// Command address increment, including the wrap of all ones
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 21'h1FFFFF : (i == 1) ? 21'h0FFFFF : 21'($urandom());
			wr_reg(`CAC_OFF_CMD_ADDR, aword(a));
			run_op(CAC_OP_CMD_INC, 2'($urandom()));
			a = a + 21'h1;
			chk_op({a, 3'h0}, 24'hFFFFF8, `CAC_OFF_CMD_ADDR, aword(a), 32'h30);
		end
		wr_reg(`CAC_OFF_STATUS, 32'h1);
		rd_reg(`CAC_OFF_STATUS, 32'h30);
		repeat (3) @(posedge i_sys_clk);
		final_report();
	end
endmodule
